// ===== shared/sit_if.sv
// two-wire bus between host end and target end
// resolves open-drain scl from the host enable and sda from the enables of both parties
`timescale 1ns/100ps
interface sit_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_h_out;
  logic sda_h_oe_n;
  logic sda_d_out;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // -------------------------------------------------------------
  // wired-and with pull-ups
  // -------------------------------------------------------------
  assign scl = scl_oe_n | scl_out;
  assign sda = (sda_h_oe_n | sda_h_out) & (sda_d_oe_n | sda_d_out);

  modport host (output scl_out, output scl_oe_n, output sda_h_out,
    output sda_h_oe_n, input scl, input sda);
  modport dev (output sda_d_out, output sda_d_oe_n, input scl, input sda);
endinterface : sit_if

// ===== shared/sit_pkg.sv
// types shared by the target end and the host end
// assumes nothing beyond a SystemVerilog compiler
package sit_pkg;

  // -------------------------------------------------------------
  // target state machine
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110,
    ST_IGNORE = 3'b111
  } sit_dev_state_t;

  // -------------------------------------------------------------
  // host commands
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_STOP = 2'b11
  } sit_op_t;

  typedef enum logic {
    HS_IDLE = 1'b0,
    HS_RUN = 1'b1
  } sit_host_state_t;

endpackage : sit_pkg

// ===== shared/sit_regs.svh
// constants for the sensor bus target and its host end
// assumes a 40 MHz core clock on both ends
`ifndef SIT_REGS_SVH
`define SIT_REGS_SVH

// ---------------------------------------------------------------
// addressing
// ---------------------------------------------------------------
`define SIT_OWN_ADDR 7'h60
`define SIT_GCALL_ADDR 7'h00
`define SIT_CTRL1_OFS 8'h10
`define SIT_CTRL1_RST 8'h00
`define SIT_RUN_BIT 0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SIT_CLK_NS 25
`define SIT_QTR_NS 625
`define SIT_QTR_CYC ((`SIT_QTR_NS + `SIT_CLK_NS - 1) / `SIT_CLK_NS)

// ---------------------------------------------------------------
// write stream
// ---------------------------------------------------------------
`define SIT_FIFO_WIDTH 16
`define SIT_FIFO_DEPTH 16

`endif

// ===== sim/sit_bus_chk.sv
// assertion checker for the two-wire bus between host and target
// assumes it sees the resolved wires and every party's enable
`timescale 1ns/100ps
`include "sit_regs.svh"
module sit_bus_chk #(
  parameter logic [6:0] OWN_ADDR = `SIT_OWN_ADDR
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_h_out,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_out,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, first, ign, start_s, stop_s, ack_rise;
  logic [3:0] bits, low_cnt;
  logic [7:0] sh;
  assign start_s = scl && scl_q && sda_q && !sda;
  assign stop_s = scl && scl_q && !sda_q && sda;
  assign ack_rise = scl && !scl_q && bits == 4'h8 && first;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------
  // wire decode
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // wires are clean in simulation, so no filtering before decode
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bits <= 4'h0;
      first <= 1'b0;
    end else if (start_s) begin
      bits <= 4'h0;
      first <= 1'b1;
    end else if (scl && !scl_q) begin
      if (bits == 4'h8) begin
        bits <= 4'h0;
        first <= 1'b0;
      end else begin
        bits <= bits + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n || start_s || stop_s)
      ign <= 1'b0;
    else if (ack_rise && sh[7:1] != OWN_ADDR)
      ign <= 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n || scl)
      low_cnt <= 4'h0;
    else if (low_cnt != 4'hf)
      low_cnt <= low_cnt + 4'h1;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // scl from host only
  property p_scl_host; !scl |-> !scl_oe_n; endproperty
  a_scl_host: assert property (p_scl_host)
    else $error("scl low without host pull");
  property p_cond_host; scl && scl_q && sda != sda_q |-> sda_h_oe_n != $past(sda_h_oe_n); endproperty
  a_cond_host: assert property (p_cond_host)
    else $error("sda moved in scl high not by host");
  property p_dev_stable; scl && scl_q |-> $stable(sda_d_oe_n); endproperty
  a_dev_stable: assert property (p_dev_stable)
    else $error("target sda changed while scl high");
  property p_pause; !scl && low_cnt > 4'h6 |-> $stable(sda_d_oe_n); endproperty
  a_pause: assert property (p_pause)
    else $error("target sda changed during scl pause");
  property p_no_ack; ack_rise && sh[7:1] != OWN_ADDR |-> sda; endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("foreign address acknowledged");
  property p_own_ack; ack_rise && sh[7:1] == OWN_ADDR |-> !sda; endproperty
  a_own_ack: assert property (p_own_ack)
    else $error("own address not acknowledged");
  property p_ack_hold; ack_rise && !sda |=> (!sda && scl)[*3]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack not held through scl high");
  property p_ignore; ign |-> sda_d_oe_n; endproperty
  a_ignore: assert property (p_ignore)
    else $error("target drove sda after foreign address");
endmodule : sit_bus_chk

// ===== sim/tb_top.sv
// testbench joining host end and target end over the two-wire bus
// assumes the design files and the shared interface are compiled first
`timescale 1ns/100ps
`include "sit_regs.svh"
module tb_top;
  logic core_clk, reset_n, cmd_valid, cmd_last, wr_ready, cmd_ready;
  logic resp_valid, resp_nack, wr_valid, run_select_bit, analog_en;
  logic bus_busy;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data, rd_data, resp_data, wr_addr, wr_data, rd_addr;
  logic [15:0] got_q[$];
  int fail_count, checked, cyc, resp_seen;
  logic [8:0] rows [5] = '{{8'hc0, 1'b0}, {8'h00, 1'b1}, {8'hc2, 1'b1},
    {8'h40, 1'b1}, {8'he1, 1'b1}};

  sit_if bus ();
  sit_host #(.QTR_CYC(4)) i_sit_host (.core_clk(core_clk),
    .reset_n(reset_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_nack(resp_nack));
  sit_target i_sit_target (.core_clk(core_clk), .reset_n(reset_n),
    .bus(bus), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .run_select_bit(run_select_bit), .analog_en(analog_en),
    .bus_busy(bus_busy));
  sit_bus_chk i_sit_bus_chk (.core_clk(core_clk), .reset_n(reset_n),
    .scl_out(bus.scl_out), .scl_oe_n(bus.scl_oe_n),
    .sda_h_out(bus.sda_h_out), .sda_h_oe_n(bus.sda_h_oe_n),
    .sda_d_out(bus.sda_d_out), .sda_d_oe_n(bus.sda_d_oe_n),
    .scl(bus.scl), .sda(bus.sda));

  // ---------------------------------------------------------------
  // clock, readback source, write sink, timeout
  // ---------------------------------------------------------------
  // readback pattern depends on pointer so a stale byte shows
  assign rd_data = rd_addr ^ 8'h5a;
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got_q.push_back({wr_addr, wr_data});
  end
  // every byte op must pulse resp_valid exactly once
  always @(posedge core_clk) begin
    if (resp_valid === 1'b1)
      resp_seen++;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  task automatic bus_op(input logic [1:0] op, input logic [7:0] d,
    input logic l);
    int n;
    int r0;
    n = 0;
    r0 = resp_seen;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_last <= l;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++n < 2000);
    cmd_valid <= 1'b0;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++n < 4000);
    check("resp_valid", 16'(op[0] ^ op[1]), 16'(resp_seen - r0));
  endtask : bus_op
  task automatic ctrl_set(input logic [7:0] v);
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc0, 1'b0);
    bus_op(sit_pkg::OP_WRITE, `SIT_CTRL1_OFS, 1'b0);
    bus_op(sit_pkg::OP_WRITE, v, 1'b0);
    repeat (6) @(posedge core_clk);
    check("run_select_bit", 16'(v[0]), 16'(run_select_bit));
    check("analog_en", 16'(v[0]), 16'(analog_en));
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc0, 1'b0);
    bus_op(sit_pkg::OP_WRITE, `SIT_CTRL1_OFS, 1'b0);
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc1, 1'b0);
    bus_op(sit_pkg::OP_READ, 8'h00, 1'b1);
    check("control readback", 16'(v), 16'(resp_data));
    bus_op(sit_pkg::OP_STOP, 8'h00, 1'b0);
    repeat (4) @(posedge core_clk);
    check("stored word", {`SIT_CTRL1_OFS, v},
      got_q.size() > 0 ? got_q.pop_front() : 16'hxxxx);
  endtask : ctrl_set
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    wr_ready = 1'b1;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
      check("bus_busy", 16'h0001, 16'(bus_busy));
      bus_op(sit_pkg::OP_WRITE, rows[i][8:1], 1'b0);
      check("address nack", 16'(rows[i][0]), 16'(resp_nack));
      bus_op(sit_pkg::OP_STOP, 8'h00, 1'b0);
      repeat (4) @(posedge core_clk);
      check("bus_busy", 16'h0000, 16'(bus_busy));
    end
    $display("test address table done");
    for (int i = 0; i < 3; i++)
      ctrl_set(i == 1 ? 8'h00 : 8'h01);
    $display("test mode control done");
    // second reset drops active mode and releases the bus
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("run_select_bit", 16'h0000, 16'(run_select_bit));
    check("analog_en", 16'h0000, 16'(analog_en));
    check("rd_addr", 16'h0000, 16'(rd_addr));
    check("sda_d_oe_n", 16'h0001, 16'(bus.sda_d_oe_n));
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    $display("test reset done");
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc0, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'h20, 1'b0);
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc1, 1'b0);
    for (int j = 0; j < 3; j++) begin
      if (j == 1)
        repeat (40) @(posedge core_clk);
      bus_op(sit_pkg::OP_READ, 8'h00, j == 2);
      check("read byte", 16'((8'h20 + j) ^ 8'h5a), 16'(resp_data));
    end
    bus_op(sit_pkg::OP_STOP, 8'h00, 1'b0);
    $display("test burst read done");
    wr_ready <= 1'b0;
    bus_op(sit_pkg::OP_START, 8'h00, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'hc0, 1'b0);
    bus_op(sit_pkg::OP_WRITE, 8'h30, 1'b0);
    for (int j = 0; j < 18; j++) begin
      bus_op(sit_pkg::OP_WRITE, 8'(j), 1'b0);
      check("data nack", 16'(j == 17), 16'(resp_nack));
    end
    bus_op(sit_pkg::OP_STOP, 8'h00, 1'b0);
    check("wr_valid", 16'h0001, 16'(wr_valid));
    wr_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("fifo words", 16'h0011, 16'(got_q.size()));
    for (int j = 0; j < 17 && got_q.size() > 0; j++)
      check("fifo word", {8'h30 + 8'(j), 8'(j)}, got_q.pop_front());
    $display("test fifo fill done");
    complete_run();
  end
endmodule : tb_top

// ===== verilog/sit_host.sv
// host end of the sensor two-wire bus
// makes scl by dividing core_clk; one command at a time from the user
`timescale 1ns/100ps
`include "sit_regs.svh"

module sit_host #(
  parameter int QTR_CYC = `SIT_QTR_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  sit_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_nack
);
  logic [1:0] sda_sync_reg;
  sit_pkg::sit_host_state_t state_reg;
  sit_pkg::sit_op_t op_reg;
  logic [15:0] tmr_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] data_reg;
  logic [7:0] rx_reg;
  logic last_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic ready_reg;
  logic resp_valid_reg;
  logic [7:0] resp_data_reg;
  logic resp_nack_reg;
  logic tick;
  logic sda_s;

  // ---------------------------------------------------------------
  // sda sampling and quarter-bit timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  assign sda_s = sda_sync_reg[1];
  assign tick = (state_reg == sit_pkg::HS_RUN) &&
                (tmr_reg == 16'(QTR_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!reset_n || state_reg == sit_pkg::HS_IDLE || tick) begin
      tmr_reg <= 16'h0000;
    end else begin
      tmr_reg <= tmr_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  // between commands scl stays where the last one left it, so an idle
  // user between start and stop simply holds scl low and pauses the target
  always_ff @(posedge core_clk) begin
    resp_valid_reg <= 1'b0;
    if (!reset_n) begin
      state_reg <= sit_pkg::HS_IDLE;
      op_reg <= sit_pkg::OP_START;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      data_reg <= 8'h00;
      rx_reg <= 8'h00;
      last_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      ready_reg <= 1'b0;
      resp_valid_reg <= 1'b0;
      resp_data_reg <= 8'h00;
      resp_nack_reg <= 1'b0;
    end else if (state_reg == sit_pkg::HS_IDLE) begin
      ready_reg <= 1'b1;
      if (cmd_valid && ready_reg) begin
        ready_reg <= 1'b0;
        op_reg <= sit_pkg::sit_op_t'(cmd_op);
        data_reg <= cmd_data;
        last_reg <= cmd_last;
        q_reg <= 2'h0;
        bit_reg <= 4'h0;
        state_reg <= sit_pkg::HS_RUN;
      end
    end else if (tick) begin
      q_reg <= q_reg + 2'h1;
      unique case (op_reg)
        sit_pkg::OP_START: begin
          // sda falls with scl high, also as repeat
          unique case (q_reg)
            2'h0: sda_oe_n_reg <= 1'b1;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: sda_oe_n_reg <= 1'b0;
            2'h3: begin
              scl_oe_n_reg <= 1'b0;
              state_reg <= sit_pkg::HS_IDLE;
            end
          endcase
        end
        sit_pkg::OP_STOP: begin
          unique case (q_reg)
            2'h0: sda_oe_n_reg <= 1'b0;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: sda_oe_n_reg <= 1'b1;
            2'h3: state_reg <= sit_pkg::HS_IDLE;
          endcase
        end
        sit_pkg::OP_WRITE, sit_pkg::OP_READ: begin
          unique case (q_reg)
            2'h0: begin
              // eight data bits, then ack slot
              if (bit_reg != 4'h8) begin
                sda_oe_n_reg <= (op_reg == sit_pkg::OP_WRITE) ? data_reg[7]
                                                            : 1'b1;
              end else begin
                sda_oe_n_reg <= (op_reg == sit_pkg::OP_WRITE) ? 1'b1
                                                            : last_reg;
              end
            end
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: begin
            end
            2'h3: begin
              scl_oe_n_reg <= 1'b0;
              if (bit_reg == 4'h8) begin
                resp_valid_reg <= 1'b1;
                resp_data_reg <= rx_reg;
                resp_nack_reg <= sda_s;
                state_reg <= sit_pkg::HS_IDLE;
              end else begin
                rx_reg <= {rx_reg[6:0], sda_s};
                data_reg <= {data_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          endcase
        end
      endcase
    end
  end

  // scl held low only while scl_oe_n_reg is low; released after reset and after a stop
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe_n = scl_oe_n_reg;
  assign bus.sda_h_out = 1'b0;
  assign bus.sda_h_oe_n = sda_oe_n_reg;
  assign cmd_ready = ready_reg;
  assign resp_valid = resp_valid_reg;
  assign resp_data = resp_data_reg;
  assign resp_nack = resp_nack_reg;
endmodule : sit_host

// ===== verilog/sit_target.sv
// target end of the sensor two-wire bus, with mode control
// assumes scl and sda arrive asynchronously; writes leave by a fifo
`timescale 1ns/100ps
`include "sit_regs.svh"

module sit_fifo #(
  parameter int WIDTH = `SIT_FIFO_WIDTH,
  parameter int DEPTH = `SIT_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = in_valid & in_ready;
  // output register keeps the user port glitch free
  assign pop = (count_reg != '0) & (~out_valid_reg | out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem_reg[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule : sit_fifo

module sit_target #(
  parameter logic [6:0] OWN_ADDR = `SIT_OWN_ADDR,
  parameter int FIFO_DEPTH = `SIT_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  sit_if.dev bus,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic run_select_bit,
  output logic analog_en,
  output logic bus_busy
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  sit_pkg::sit_dev_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic first_reg;
  logic host_ack_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_n_reg;
  logic busy_reg;
  logic [7:0] ctrl_reg;
  logic analog_reg;
  logic push_reg;
  logic [15:0] push_data_reg;
  logic fifo_ready;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] tx_src;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  // stored control byte is served in any mode
  assign tx_src = (ptr_reg == `SIT_CTRL1_OFS) ? ctrl_reg : rd_data;

  // ---------------------------------------------------------------
  // bus occupancy
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (start_seen) begin
      busy_reg <= 1'b1;
    end else if (stop_seen) begin
      busy_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  // scl is only watched, never driven: no stretching
  // no scl driver
  always_ff @(posedge core_clk) begin
    push_reg <= 1'b0;
    if (!reset_n) begin
      state_reg <= sit_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe_n_reg <= 1'b1;
      ctrl_reg <= `SIT_CTRL1_RST;
      push_reg <= 1'b0;
      push_data_reg <= 16'h0000;
    end else if (start_seen) begin
      state_reg <= sit_pkg::ST_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (stop_seen) begin
      state_reg <= sit_pkg::ST_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else if (scl_rise) begin
      if (state_reg == sit_pkg::ST_ADDR || state_reg == sit_pkg::ST_WDATA) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        cnt_reg <= cnt_reg + 4'h1;
      end else if (state_reg == sit_pkg::ST_RACK) begin
        host_ack_reg <= ~sda_s;
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        sit_pkg::ST_ADDR: begin
          if (cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == OWN_ADDR &&
                shift_reg[7:1] != `SIT_GCALL_ADDR) begin
              rw_reg <= shift_reg[0];
              sda_oe_n_reg <= 1'b0;
              state_reg <= sit_pkg::ST_ADDR_ACK;
            end else begin
              state_reg <= sit_pkg::ST_IGNORE;
            end
          end
        end
        sit_pkg::ST_ADDR_ACK, sit_pkg::ST_RACK: begin
          if ((state_reg == sit_pkg::ST_ADDR_ACK && rw_reg) ||
              (state_reg == sit_pkg::ST_RACK && host_ack_reg)) begin
            // next byte, pointer advances without limit
            sda_oe_n_reg <= tx_src[7];
            tx_reg <= {tx_src[6:0], 1'b0};
            ptr_reg <= ptr_reg + 8'h01;
            cnt_reg <= 4'h1;
            state_reg <= sit_pkg::ST_RDATA;
          end else if (state_reg == sit_pkg::ST_ADDR_ACK) begin
            sda_oe_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            first_reg <= 1'b1;
            state_reg <= sit_pkg::ST_WDATA;
          end else begin
            state_reg <= sit_pkg::ST_IGNORE;
          end
        end
        sit_pkg::ST_RDATA: begin
          // bits move only on host clock edges
          if (cnt_reg == 4'h8) begin
            sda_oe_n_reg <= 1'b1;
            state_reg <= sit_pkg::ST_RACK;
          end else begin
            sda_oe_n_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        sit_pkg::ST_WDATA: begin
          if (cnt_reg == 4'h8) begin
            // a full fifo cannot stall the host, so the byte is refused
            if (first_reg || fifo_ready) begin
              sda_oe_n_reg <= 1'b0;
              state_reg <= sit_pkg::ST_WACK;
              if (first_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                push_reg <= 1'b1;
                push_data_reg <= {ptr_reg, shift_reg};
                ptr_reg <= ptr_reg + 8'h01;
                if (ptr_reg == `SIT_CTRL1_OFS) begin
                  ctrl_reg <= shift_reg;
                end
              end
            end else begin
              state_reg <= sit_pkg::ST_IGNORE;
            end
          end
        end
        sit_pkg::ST_WACK: begin
          sda_oe_n_reg <= 1'b1;
          cnt_reg <= 4'h0;
          first_reg <= 1'b0;
          state_reg <= sit_pkg::ST_WDATA;
        end
        sit_pkg::ST_IDLE, sit_pkg::ST_IGNORE: begin
          sda_oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      analog_reg <= 1'b0;
    end else begin
      analog_reg <= ctrl_reg[`SIT_RUN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // write stream
  // ---------------------------------------------------------------
  sit_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .in_data(push_data_reg),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  assign bus.sda_d_out = 1'b0;
  assign bus.sda_d_oe_n = sda_oe_n_reg;
  assign rd_addr = ptr_reg;
  assign run_select_bit = ctrl_reg[`SIT_RUN_BIT];
  assign analog_en = analog_reg;
  assign bus_busy = busy_reg;
endmodule : sit_target
